// [src/dsx_exchange.v]
// Purpose: Triple-buffered output and input exchange, watchdog and global control.
// Assumes: Host bus strobes and bus-side events are one-cycle pulses on clk.
// Notes: Bus exchange requests wait while a host command read uses the same path.
`timescale 1ns/10ps
`include "dsx_map.vh"
module dsx_exchange (
  input wire clk,
  input wire rst_n,
  input wire [7:0] host_addr,
  input wire host_rd,
  input wire host_wr,
  input wire [7:0] host_wdata,
  output reg [7:0] host_rdata,
  input wire out_byte_valid,
  output wire out_byte_ready,
  input wire [7:0] out_byte,
  input wire out_byte_last,
  input wire wrd_received,
  input wire prm_cfg_done,
  input wire in_send_req,
  input wire [2:0] in_rd_addr,
  output reg [7:0] in_rd_data,
  input wire [2:0] ro_addr,
  output reg [7:0] ro_data,
  input wire gc_valid,
  input wire [7:0] gc_cmd,
  input wire [7:0] gc_group,
  input wire [7:0] group_ident,
  input wire sync_enable,
  input wire freeze_enable,
  input wire [15:0] host_watchdog_start_value,
  input wire host_watchdog_reload_set,
  input wire change_cfg_enable,
  input wire cfg_swap_req,
  output reg host_watchdog_reload_bit,
  output reg [15:0] host_watchdog_counter,
  output reg data_exchange,
  output reg leave_master,
  output reg output_received_irq,
  output reg global_command_changed_irq,
  output reg [7:0] global_control_byte,
  output reg cfg_read_sel,
  output reg freeze_active,
  output reg sync_active
);
  // Buffer memories; index is {pointer, byte}, pointer 0 is never used.
  reg [7:0] out_mem [0:31];
  reg [7:0] in_mem [0:31];
  // Output path pointers and flags.
  reg [1:0] od;
  reg [1:0] on;
  reg [1:0] ou;
  reg [1:0] of;
  reg o_new;
  reg n_clr;
  reg u_clr;
  reg o_xreq;
  reg o_xclr;
  reg d_dirty;
  reg clr_busy;
  reg [2:0] clr_cnt;
  reg [2:0] wr_cnt;
  // Input path pointers and flags.
  reg [1:0] id;
  reg [1:0] inn;
  reg [1:0] iu;
  reg [1:0] ifr;
  reg i_new;
  reg i_sreq;
  // Buffered output byte stream.
  wire fifo_valid;
  wire [8:0] fifo_data;
  wire drain;
  wire host_nxt;
  wire host_nin;
  wire o_exec;
  wire gc_take;
  wire gc_clear;
  wire gc_sync;
  wire gc_unsync;
  wire gc_freeze;
  wire gc_unfreeze;
  wire frame_end;
  wire wd_expire;
  wire clr_start;
  wire o_set;
  wire i_set;
  wire [15:0] wd_dec;
  // High while D must not take new bytes: during the clear and until a queued exchange runs.
  wire d_hold;

  // A stall while D is being cleared backs up into the bus receiver.
  // The stall also covers the cycle in which a queued exchange moves D away, so the
  // first byte of the next frame always lands in the new D and never in the old one.
  // Two entries are enough: the bus receiver waits on ready during the hold, so no
  // byte is dropped.
  dsx_pair_fifo #(
    .WIDTH(9)
  ) u_pair (
    .clk(clk),
    .rst_n(rst_n),
    .in_valid(out_byte_valid),
    .in_ready(out_byte_ready),
    .in_data({out_byte_last, out_byte}),
    .out_valid(fifo_valid),
    .out_ready(~d_hold),
    .out_data(fifo_data)
  );

  // Decode of command reads and global control events.
  // Holding on a queued exchange costs one cycle of stream rate per frame, which is
  // far below the byte rate of the link; in return D splits across two buffers only when a sync or unsync command exchanges it mid-frame.
  assign d_hold = clr_busy | o_xreq;
  assign drain = fifo_valid & ~d_hold;
  assign host_nxt = host_rd & (host_addr == `DSX_OFS_OUT_CMD);
  assign host_nin = host_rd & (host_addr == `DSX_OFS_IN_CMD);
  assign o_exec = o_xreq & ~clr_busy & ~host_nxt;
  assign gc_take = gc_valid & ((gc_group == 8'h00) | ((gc_group & group_ident) != 8'h00));
  assign gc_clear = gc_take & gc_cmd[`DSX_GC_CLEAR];
  assign gc_unfreeze = gc_take & gc_cmd[`DSX_GC_UNFREEZE];
  assign gc_freeze = gc_take & gc_cmd[`DSX_GC_FREEZE] & freeze_enable;
  assign gc_unsync = gc_take & gc_cmd[`DSX_GC_UNSYNC];
  assign gc_sync = gc_take & gc_cmd[`DSX_GC_SYNC] & sync_enable;
  assign frame_end = drain & fifo_data[8];
  assign wd_dec = host_watchdog_counter - 16'h0001;
  assign wd_expire = wrd_received & data_exchange & ~host_watchdog_reload_bit
    & (wd_dec == 16'h0000);
  assign clr_start = gc_clear | wd_expire;
  // Plain frame ends exchange at once unless sync holds them in D.
  assign o_set = (frame_end & ~sync_active) | ((gc_sync | (gc_unsync & sync_active))
    & d_dirty);
  assign i_set = (in_send_req & ~freeze_active) | gc_freeze;

  // Output memory: the clear sequence and the stream share one write port.
  always @(posedge clk) begin
    if (clr_busy) begin
      out_mem[{od, clr_cnt}] <= 8'h00;
    end else if (drain) begin
      out_mem[{od, wr_cnt}] <= fifo_data[7:0];
    end
    if (host_wr && host_addr[7:3] == `DSX_OFS_IN_WIN) begin
      in_mem[{iu, host_addr[2:0]}] <= host_wdata;
    end
  end

  // Clear sequence and write position; runs after reset and again on a clear command or watchdog expiry.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      clr_busy <= 1'b1;
      clr_cnt <= 3'h0;
      wr_cnt <= 3'h0;
    end else begin
      if (clr_busy) begin
        clr_cnt <= clr_cnt + 3'h1;
        wr_cnt <= 3'h0;
        if (clr_cnt == `DSX_BUF_LAST) begin
          clr_busy <= 1'b0;
        end
      end else if (clr_start) begin
        clr_busy <= 1'b1;
        clr_cnt <= 3'h0;
      end else if (drain) begin
        wr_cnt <= fifo_data[8] ? 3'h0 : wr_cnt + 3'h1;
      end
    end
  end

  // Output pointers: host fetch of N wins, a bus exchange waits one cycle.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      od <= `DSX_PTR_D_RESET;
      on <= `DSX_PTR_NIL;
      ou <= `DSX_PTR_U_RESET;
      of <= `DSX_PTR_F_RESET;
      o_new <= 1'b0;
      n_clr <= 1'b0;
      u_clr <= 1'b0;
      o_xreq <= 1'b0;
      o_xclr <= 1'b0;
      d_dirty <= 1'b0;
    end else begin
      if (host_nxt && o_new) begin
        ou <= on;
        of <= ou;
        on <= `DSX_PTR_NIL;
        o_new <= 1'b0;
        u_clr <= n_clr;
      end else if (o_exec) begin
        on <= od;
        if (on == `DSX_PTR_NIL) begin
          od <= of;
          of <= `DSX_PTR_NIL;
        end else begin
          od <= on;
        end
        o_new <= 1'b1;
        n_clr <= o_xclr;
      end
      // A new request in the cycle its predecessor runs is kept.
      if (clr_busy && clr_cnt == `DSX_BUF_LAST) begin
        o_xreq <= 1'b1;
        o_xclr <= 1'b1;
      end else if (o_set) begin
        o_xreq <= 1'b1;
        o_xclr <= 1'b0;
      end else if (o_exec) begin
        o_xreq <= 1'b0;
      end
      if (drain) begin
        d_dirty <= 1'b1;
      end else if (o_exec) begin
        d_dirty <= 1'b0;
      end
    end
  end

  // Input pointers: host command read moves U to N, bus moves N to D.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      id <= `DSX_PTR_D_RESET;
      inn <= `DSX_PTR_NIL;
      iu <= `DSX_PTR_U_RESET;
      ifr <= `DSX_PTR_F_RESET;
      i_new <= 1'b0;
      i_sreq <= 1'b0;
    end else begin
      if (host_nin) begin
        inn <= iu;
        if (inn == `DSX_PTR_NIL) begin
          iu <= ifr;
          ifr <= `DSX_PTR_NIL;
        end else begin
          iu <= inn;
        end
        i_new <= 1'b1;
      end else if (i_sreq && i_new) begin
        id <= inn;
        ifr <= id;
        inn <= `DSX_PTR_NIL;
        i_new <= 1'b0;
      end
      if (i_set) begin
        i_sreq <= 1'b1;
      end else if (!host_nin) begin
        i_sreq <= 1'b0;
      end
    end
  end

  // Freeze and sync modes follow accepted global commands; freeze and sync are entered only while their enable is set.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      freeze_active <= 1'b0;
      sync_active <= 1'b0;
      global_control_byte <= `DSX_GC_RESET;
      global_command_changed_irq <= 1'b0;
      output_received_irq <= 1'b0;
    end else begin
      if (gc_freeze) begin
        freeze_active <= 1'b1;
      end else if (gc_unfreeze) begin
        freeze_active <= 1'b0;
      end
      if (gc_sync) begin
        sync_active <= 1'b1;
      end else if (gc_unsync) begin
        sync_active <= 1'b0;
      end
      if (gc_take) begin
        global_control_byte <= gc_cmd;
      end
      global_command_changed_irq <= gc_take & (gc_cmd != global_control_byte);
      output_received_irq <= o_exec & ~o_xclr;
    end
  end

  // Watchdog and data exchange state.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_watchdog_counter <= `DSX_WD_RESET;
      host_watchdog_reload_bit <= 1'b0;
      data_exchange <= 1'b0;
      leave_master <= 1'b0;
      cfg_read_sel <= 1'b0;
    end else begin
      leave_master <= wd_expire;
      if (wrd_received && host_watchdog_reload_bit) begin
        host_watchdog_counter <= host_watchdog_start_value;
        host_watchdog_reload_bit <= 1'b0;
      end else begin
        if (host_watchdog_reload_set) begin
          host_watchdog_reload_bit <= 1'b1;
        end
        if (wrd_received && data_exchange && host_watchdog_counter != 16'h0000) begin
          host_watchdog_counter <= wd_dec;
        end
      end
      if (host_watchdog_reload_set) begin
        host_watchdog_reload_bit <= 1'b1;
      end
      if (wd_expire) begin
        data_exchange <= 1'b0;
      end else if (prm_cfg_done) begin
        data_exchange <= 1'b1;
      end
      if (cfg_swap_req && change_cfg_enable) begin
        cfg_read_sel <= ~cfg_read_sel;
      end
    end
  end

  // Host reads; command cells report the state after their own exchange.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      host_rdata <= 8'h00;
      in_rd_data <= 8'h00;
      ro_data <= 8'h00;
    end else begin
      in_rd_data <= in_mem[{id, in_rd_addr}];
      ro_data <= out_mem[{ou, ro_addr}];
      if (host_rd) begin
        if (host_addr == `DSX_OFS_IN_STATE) begin
          host_rdata <= {ifr, iu, inn, id};
        end else if (host_addr == `DSX_OFS_IN_CMD) begin
          host_rdata <= {6'h00, (inn == `DSX_PTR_NIL) ? ifr : inn};
        end else if (host_addr == `DSX_OFS_OUT_STATE) begin
          host_rdata <= {of, ou, on, od};
        end else if (host_addr == `DSX_OFS_OUT_CMD) begin
          host_rdata <= o_new ? {4'h0, n_clr, 1'b1, on} : {4'h0, u_clr, 1'b0, ou};
        end else if (host_addr == `DSX_OFS_GC_BYTE) begin
          host_rdata <= global_control_byte;
        end else if (host_addr[7:3] == `DSX_OFS_OUT_WIN) begin
          host_rdata <= out_mem[{ou, host_addr[2:0]}];
        end else begin
          host_rdata <= 8'h00;
        end
      end
    end
  end
endmodule // dsx_exchange

// [src/dsx_map.vh]
// Purpose: Offsets, field positions, reset values and counts of the data exchange block.
// Assumes: Byte-wide host bus on the system clock; three buffers per data direction.
// Notes: Pointer code 0 means no buffer, codes 1 to 3 name the buffers.
`ifndef DSX_MAP_VH
`define DSX_MAP_VH
`define DSX_OFS_IN_STATE 8'h08
`define DSX_OFS_IN_CMD 8'h09
`define DSX_OFS_OUT_STATE 8'h0a
`define DSX_OFS_OUT_CMD 8'h0b
`define DSX_OFS_GC_BYTE 8'h3c
`define DSX_OFS_OUT_WIN 5'b01000
`define DSX_OFS_IN_WIN 5'b01001
`define DSX_GC_RESET 8'h00
`define DSX_GC_CLEAR 1
`define DSX_GC_UNFREEZE 2
`define DSX_GC_FREEZE 3
`define DSX_GC_UNSYNC 4
`define DSX_GC_SYNC 5
`define DSX_PTR_NIL 2'b00
`define DSX_PTR_D_RESET 2'b01
`define DSX_PTR_U_RESET 2'b10
`define DSX_PTR_F_RESET 2'b11
`define DSX_BUF_LAST 3'h7
`define DSX_WD_RESET 16'h0000
`endif

// [src/dsx_pair_fifo.v]
// Purpose: Two-entry buffer with valid and ready on both sides.
// Assumes: Source and sink share the block clock.
// Notes: Full and empty are exact; ready drops only when both entries hold data.
`timescale 1ns/10ps
module dsx_pair_fifo #(
  parameter WIDTH = 9
) (
  input wire clk,
  input wire rst_n,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  reg [WIDTH-1:0] slot [0:1];
  reg wr_ptr;
  reg rd_ptr;
  reg [1:0] count;
  wire do_push;
  wire do_pop;

  // Handshakes complete only when both sides agree.
  assign in_ready = (count != 2'd2);
  assign out_valid = (count != 2'd0);
  assign out_data = slot[rd_ptr];
  assign do_push = in_valid & in_ready;
  assign do_pop = out_valid & out_ready;

  // Storage carries no reset; count alone says what is valid.
  always @(posedge clk) begin
    if (do_push) begin
      slot[wr_ptr] <= in_data;
    end
  end

  // Pointers and occupancy.
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count <= 2'd0;
    end else begin
      if (do_push) begin
        wr_ptr <= ~wr_ptr;
      end
      if (do_pop) begin
        rd_ptr <= ~rd_ptr;
      end
      if (do_push && !do_pop) begin
        count <= count + 2'd1;
      end else if (do_pop && !do_push) begin
        count <= count - 2'd1;
      end
    end
  end
endmodule // dsx_pair_fifo

// [tb/dsx_exchange_monitor.sv]
// Purpose: Port-level checks for the data exchange block.
// Assumes: One clock domain, reset asynchronous and active low.
// Notes: Group select zero reaches every slave, so it is the easy trigger.
`timescale 1ns/10ps
module dsx_exchange_monitor (
  input wire clk,
  input wire rst_n,
  input wire gc_valid,
  input wire [7:0] gc_cmd,
  input wire [7:0] gc_group,
  input wire sync_enable,
  input wire freeze_enable,
  input wire wrd_received,
  input wire [15:0] host_watchdog_start_value,
  input wire host_watchdog_reload_set,
  input wire host_watchdog_reload_bit,
  input wire [15:0] host_watchdog_counter,
  input wire data_exchange,
  input wire leave_master,
  input wire global_command_changed_irq,
  input wire [7:0] global_control_byte,
  input wire change_cfg_enable,
  input wire cfg_swap_req,
  input wire cfg_read_sel,
  input wire freeze_active,
  input wire sync_active
);
  // All checks share the block clock and reset.
  default clocking @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  // A broadcast control telegram, accepted by every slave.
  wire gc_all = gc_valid && (gc_group == 8'h00);
  // Counts one telegram on a running counter with no reload pending.
  wire wd_tick = wrd_received && !host_watchdog_reload_bit && data_exchange;
  sequence s_leave;
    ##[1:2] leave_master ##1 (!leave_master && !data_exchange);
  endsequence
  property p_gc_store;
    gc_all |=> global_control_byte == $past(gc_cmd);
  endproperty
  a_gc_store: assert property (p_gc_store) else $error("control byte not stored");
  property p_gc_irq;
    gc_all && (gc_cmd != global_control_byte) |=> global_command_changed_irq;
  endproperty
  a_gc_irq: assert property (p_gc_irq) else $error("changed byte gave no event");
  property p_freeze;
    gc_all && freeze_enable && gc_cmd[3] && !gc_cmd[2] |-> ##[1:2] freeze_active;
  endproperty
  a_freeze: assert property (p_freeze) else $error("freeze not entered");
  property p_sync;
    gc_all && sync_enable && gc_cmd[5] && !gc_cmd[4] |-> ##[1:2] sync_active;
  endproperty
  a_sync: assert property (p_sync) else $error("sync not entered");
  property p_wd_reload;
    wrd_received && host_watchdog_reload_bit && !host_watchdog_reload_set |=>
      host_watchdog_counter == $past(host_watchdog_start_value) && !host_watchdog_reload_bit;
  endproperty
  a_wd_reload: assert property (p_wd_reload) else $error("watchdog not reloaded");
  property p_wd_dec;
    wd_tick && host_watchdog_counter > 16'h0001 |=>
      host_watchdog_counter == $past(host_watchdog_counter) - 16'h0001;
  endproperty
  a_wd_dec: assert property (p_wd_dec) else $error("watchdog did not count down");
  property p_wd_expire;
    wd_tick && host_watchdog_counter == 16'h0001 |-> s_leave;
  endproperty
  a_wd_expire: assert property (p_wd_expire) else $error("expiry did not leave");
  property p_cfg;
    cfg_swap_req && change_cfg_enable |=> cfg_read_sel != $past(cfg_read_sel);
  endproperty
  a_cfg: assert property (p_cfg) else $error("config buffers not swapped");
endmodule // dsx_exchange_monitor

// [tb/dsx_far_end.sv]
// Purpose: Master side that sends one output frame of eight bytes.
// Assumes: A byte moves on a rising edge with valid and ready both high.
// Notes: Idle data shows the inverse of the last byte, so a stale copy never passes.
`timescale 1ns/10ps
module dsx_far_end (
  input wire clk,
  input wire go,
  input wire [7:0] base,
  input wire out_byte_ready,
  output reg out_byte_valid,
  output reg [7:0] out_byte,
  output reg out_byte_last
);
  integer i;
  // Each byte is held until the edge that takes it.
  initial begin
    out_byte_valid = 1'b0;
    out_byte = 8'h00;
    out_byte_last = 1'b0;
    forever begin
      @(posedge go);
      for (i = 0; i < 8; i = i + 1) begin
        @(negedge clk);
        out_byte_valid = 1'b1;
        out_byte = base + i[7:0];
        out_byte_last = (i == 7);
        @(posedge clk);
        while (out_byte_ready !== 1'b1) @(posedge clk);
      end
      @(negedge clk);
      out_byte_valid = 1'b0;
      out_byte = ~out_byte;
      out_byte_last = 1'b0;
    end
  end
endmodule // dsx_far_end

// [tb/dsx_exchange_bench.sv]
// Purpose: Self-checking bench for the data exchange block.
// Assumes: Inputs change on the falling edge and outputs are sampled there.
// Notes: Pointer expectations follow the D, N, U, F rotation of the buffers.
`timescale 1ns/10ps
module dsx_exchange_bench;
  reg clk, rst_n, host_rd, host_wr, gc_valid, sync_enable, freeze_enable, change_cfg_enable, go;
  reg [7:0] host_addr, host_wdata, gc_cmd, gc_group, group_ident, fbase, d;
  reg [2:0] in_rd_addr, ro_addr;
  reg [4:0] st;
  reg [15:0] host_watchdog_start_value;
  wire out_byte_valid, out_byte_ready, out_byte_last, host_watchdog_reload_bit, data_exchange;
  wire leave_master, output_received_irq, global_command_changed_irq, cfg_read_sel;
  wire freeze_active, sync_active;
  wire [7:0] host_rdata, out_byte, in_rd_data, ro_data, global_control_byte;
  wire [15:0] host_watchdog_counter;
  integer n_errors, checked, k;
  integer n_rx = 0;
  // Counts output-received events, since a one-cycle pulse is easily missed by a task.
  always @(posedge clk) begin
    if (output_received_irq === 1'b1) begin
      n_rx <= n_rx + 1;
    end
  end
  // Status flags gathered so one compare can mask any of them.
  wire [7:0] fl = {output_received_irq, leave_master, cfg_read_sel, sync_active,
    freeze_active, data_exchange, host_watchdog_reload_bit, global_command_changed_irq};
  dsx_exchange dut (.clk, .rst_n, .host_addr, .host_rd, .host_wr, .host_wdata, .host_rdata,
    .out_byte_valid, .out_byte_ready, .out_byte, .out_byte_last, .wrd_received(st[0]),
    .prm_cfg_done(st[2]), .in_send_req(st[1]), .in_rd_addr, .in_rd_data, .ro_addr, .ro_data,
    .gc_valid, .gc_cmd, .gc_group, .group_ident, .sync_enable, .freeze_enable,
    .host_watchdog_start_value, .host_watchdog_reload_set(st[3]), .change_cfg_enable,
    .cfg_swap_req(st[4]), .host_watchdog_reload_bit, .host_watchdog_counter, .data_exchange,
    .leave_master, .output_received_irq, .global_command_changed_irq, .global_control_byte,
    .cfg_read_sel, .freeze_active, .sync_active);
  dsx_far_end u_far (.clk, .go, .base(fbase), .out_byte_ready, .out_byte_valid, .out_byte,
    .out_byte_last);
  // Free-running 10 MHz clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Hang guard at 20000 cycles, far beyond the several hundred cycles the run needs.
  initial begin
    #2000000;
    n_errors = n_errors + 1;
    complete_run;
  end
  task complete_run;
    begin
      if (n_errors == 0 && checked > 0) begin
        $display("Testbench passed");
      end else begin
        $display("Testbench failed");
      end
      $finish;
    end
  endtask
  task chk(input [7:0] got, input [7:0] exp);
    begin
      checked = checked + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cyc(input integer n);
    begin
      repeat (n) @(negedge clk);
    end
  endtask
  // One-cycle strobes: bit 0 telegram, 1 send, 2 prm done, 3 reload, 4 config swap.
  task pulse(input [4:0] m);
    begin
      @(negedge clk);
      st = m;
      @(negedge clk);
      st = 5'h00;
    end
  endtask
  // Host reads land in d one cycle after the strobe edge.
  task rd(input [7:0] a, input [7:0] exp);
    begin
      @(negedge clk);
      host_addr = a;
      host_rd = 1'b1;
      @(negedge clk);
      host_rd = 1'b0;
      d = host_rdata;
      chk(d, exp);
    end
  endtask
  // Fills the user input buffer with an ascending pattern.
  task wr_in(input [7:0] b);
    begin
      for (k = 0; k < 8; k = k + 1) begin
        @(negedge clk);
        host_addr = 8'h48 + k[7:0];
        host_wdata = b + k[7:0];
        host_wr = 1'b1;
        @(negedge clk);
        host_wr = 1'b0;
      end
    end
  endtask
  task gc(input [7:0] c, input [7:0] g);
    begin
      @(negedge clk);
      gc_cmd = c;
      gc_group = g;
      gc_valid = 1'b1;
      @(negedge clk);
      gc_valid = 1'b0;
    end
  endtask
  task frame(input [7:0] b);
    begin
      @(negedge clk);
      fbase = b;
      go = 1'b1;
      cyc(100);
      go = 1'b0;
    end
  endtask
  // Reads a whole buffer through the read-outputs or send-inputs port.
  task dump(input sel, input [7:0] b);
    begin
      for (k = 0; k < 8; k = k + 1) begin
        @(negedge clk);
        ro_addr = k[2:0];
        in_rd_addr = k[2:0];
        @(negedge clk);
        chk(sel ? ro_data : in_rd_data, b + k[7:0]);
      end
    end
  endtask
  task t_outputs;
    begin
      rd(8'h3c, 8'h00);
      rd(8'h0a, 8'h27);
      rd(8'h0b, 8'h0d);
      rd(8'h47, 8'h00);
      rd(8'h0a, 8'h93);
      rd(8'h21, 8'h00);
      frame(8'h50);
      chk(n_rx[7:0], 8'h01);
      rd(8'h0a, 8'h1e);
      rd(8'h0b, 8'h07);
      dump(1'b1, 8'h50);
      gc(8'h02, 8'h00);
      frame(8'h70);
      chk(n_rx[7:0], 8'h02);
      rd(8'h0b, 8'h05);
      dump(1'b1, 8'h70);
    end
  endtask
  task t_inputs;
    begin
      wr_in(8'ha0);
      rd(8'h09, 8'h03);
      rd(8'h08, 8'h39);
      pulse(5'h02);
      dump(1'b0, 8'ha0);
      pulse(5'h02);
      dump(1'b0, 8'ha0);
      freeze_enable = 1'b1;
      wr_in(8'hb0);
      rd(8'h09, 8'h01);
      gc(8'h08, 8'h00);
      chk(fl & 8'h08, 8'h08);
      dump(1'b0, 8'hb0);
      wr_in(8'hc0);
      rd(8'h09, 8'h02);
      pulse(5'h02);
      dump(1'b0, 8'hb0);
      gc(8'h04, 8'h00);
      pulse(5'h02);
      dump(1'b0, 8'hc0);
    end
  endtask
  task t_sync;
    begin
      sync_enable = 1'b1;
      gc(8'h20, 8'h00);
      cyc(2);
      chk(fl & 8'h10, 8'h10);
      host_addr = 8'h0b;
      rd(8'h0b, 8'h01);
      frame(8'h60);
      rd(8'h0b, 8'h01);
      gc(8'h10, 8'h00);
      cyc(4);
      chk(n_rx[7:0], 8'h03);
      rd(8'h0b, 8'h06);
      dump(1'b1, 8'h60);
    end
  endtask
  task t_gc;
    begin
      group_ident = 8'h01;
      gc(8'h20, 8'h02);
      rd(8'h3c, 8'h10);
      for (k = 1; k < 6; k = k + 1) begin
        gc(8'h01 << k, 8'h01);
        chk(fl & 8'h01, 8'h01);
        rd(8'h3c, 8'h01 << k);
      end
      gc(8'h20, 8'h00);
      chk(fl & 8'h01, 8'h00);
    end
  endtask
  task t_wd_cfg;
    begin
      host_watchdog_start_value = 16'h0003;
      pulse(5'h08);
      chk(fl & 8'h02, 8'h02);
      pulse(5'h01);
      chk(host_watchdog_counter[7:0], 8'h03);
      chk(fl & 8'h02, 8'h00);
      pulse(5'h01);
      pulse(5'h01);
      chk(host_watchdog_counter[7:0], 8'h01);
      pulse(5'h01);
      chk(fl & 8'h40, 8'h40);
      cyc(2);
      chk(fl & 8'h04, 8'h00);
      pulse(5'h10);
      chk(fl & 8'h20, 8'h00);
      change_cfg_enable = 1'b1;
      pulse(5'h10);
      chk(fl & 8'h20, 8'h20);
    end
  endtask
  // Reset for 16 cycles, let the start-up clear finish, then run every scenario.
  initial begin
    n_errors = 0;
    checked = 0;
    {host_rd, host_wr, gc_valid, sync_enable, freeze_enable, change_cfg_enable, go, rst_n} = 8'h00;
    {host_addr, host_wdata, gc_cmd, gc_group, group_ident, fbase} = 48'h000000000000;
    {in_rd_addr, ro_addr, st} = 11'h000;
    host_watchdog_start_value = 16'h0000;
    cyc(16);
    rst_n = 1'b1;
    cyc(12);
    chk(fl & 8'h04, 8'h00);
    pulse(5'h04);
    chk(fl & 8'h04, 8'h04);
    t_outputs;
    t_inputs;
    t_sync;
    t_gc;
    t_wd_cfg;
    complete_run;
  end
endmodule // dsx_exchange_bench
bind dsx_exchange dsx_exchange_monitor u_mon (.clk, .rst_n, .gc_valid, .gc_cmd, .gc_group,
  .sync_enable, .freeze_enable, .wrd_received, .host_watchdog_start_value,
  .host_watchdog_reload_set, .host_watchdog_reload_bit, .host_watchdog_counter, .data_exchange,
  .leave_master, .global_command_changed_irq, .global_control_byte, .change_cfg_enable,
  .cfg_swap_req, .cfg_read_sel, .freeze_active, .sync_active);
